// [hw/flash_erase_ctrl.sv]
// Erase command decoder, write enable latch and self-timed erase with verify.
// Assumes raw link pins from outside (synchronised here) and a memory array
// plus protection map on the core clock that answer combinationally.
// Protection and verify answers must settle within the cycle that asks.
`timescale 1ns/1ns
`default_nettype none

// How it works
// [RULE_01] Opcodes 20h/52h/D8h erase 4K/32K/64K blocks
// [RULE_02] Block erase needs latch set beforehand
// [RULE_03] Host sends opcode then three address bytes
// [RULE_04] Extra bytes ignored; erase starts at deselect
// [RULE_05] Block erase is internally timed
// [RULE_06] Low address bits ignored per block size
// [RULE_07] Short address or ragged byte aborts erase
// [RULE_08] Protected target: no erase, back to idle
// [RULE_09] Incomplete or protected erase clears latch; a ragged chip erase frame keeps the latch here
// [RULE_10] Busy shown throughout a running erase
// [RULE_11] Latch cleared during successful erase
// [RULE_12] Host should poll busy for completion
// [RULE_13] Verify every byte; failures set error flag
// [RULE_14] Opcodes 60h and C7h both erase chip
// [RULE_15] Chip erase needs latch set beforehand
// [RULE_16] Chip erase takes no address, timed
// [RULE_17] Short opcode or ragged byte: no chip erase
// [RULE_18] Any protected sector refuses chip erase
// [RULE_19] Opcode 06h sets latch at deselect
// [RULE_20] Modifying commands need the latch set
// [RULE_21] Ragged write enable leaves latch alone
// [RULE_22] Bytes shifted in MSB first per clock
module flash_erase_ctrl #(
    parameter int BLOCK_CYCLES = flash_erase_pkg::BLOCK_ERASE_CYCLES, // Block erase length
    parameter int CHIP_CYCLES  = flash_erase_pkg::CHIP_ERASE_CYCLES   // Chip erase length
) (
    input  wire logic        core_clk_i,                 // Core clock, 100 MHz
    input  wire logic        nrst_i,                     // Synchronous reset, active low
    input  wire logic        spi_cs_n_i,                 // Chip select pin, active low
    input  wire logic        spi_sck_i,                  // Serial clock pin
    input  wire logic        spi_si_i,                   // Serial data in pin
    input  wire logic        region_protected_i,         // Query region holds a protected sector
    input  wire logic        any_protected_i,            // Some sector is protected
    input  wire logic [7:0]  verify_data_i,              // Array byte at verify_addr_o
    output logic             busy_o,                     // Erase cycle running
    output logic             write_enable_latch_o,       // Write enable latch
    output logic             erase_program_error_flag_o, // Last erase failed verify
    output logic             erase_start_o,              // One-cycle start to the array
    output logic [23:0]      erase_base_o,               // First byte to erase, then verify pointer
    output logic [23:0]      erase_last_o,               // Last byte to erase
    output logic [23:0]      region_base_o,              // Protection query start
    output logic [23:0]      region_last_o,              // Protection query end
    output logic             verify_rd_o,                // Verify read strobe
    output logic [23:0]      verify_addr_o               // Verify read address
);

    // Refuse erase cycle counts below one
    // The 32-bit timer holds any positive int count
    if (BLOCK_CYCLES < 1 || CHIP_CYCLES < 1)
    begin : g_bad_cycles
        $error("erase cycle counts must be at least one");
    end

    // All state lives in one record, filled combinationally and registered once
    flash_erase_pkg::state_t s;       // Registered state
    flash_erase_pkg::state_t next_s;  // Next state

    logic        sck_rise;      // Safe rising edge of the serial clock
    logic        cs_rise;       // Frame end
    logic        cs_fall;       // Frame start
    logic [7:0]  full_byte;     // Byte completed on this edge
    logic [23:0] low_mask;      // Ignored address bits of the block
    logic        is_block;      // Frame opcode is a block erase
    logic        is_chip;       // Frame opcode is a chip erase
    logic        aligned;       // Frame ended on a byte boundary
    logic        idle;          // No erase running

    // Edge detection works on the second flop of each synchroniser only
    // Each edge flag is one core cycle wide, so a slow serial clock still
    // shifts exactly one bit per rising edge
    assign sck_rise  = s.sck_sync[1] & ~s.sck_prev;
    assign cs_rise   = s.cs_sync[1] & ~s.cs_prev;
    assign cs_fall   = ~s.cs_sync[1] & s.cs_prev;
    assign full_byte = {s.shift[6:0], s.si_sync[1]};                      // see [RULE_22]
    assign aligned   = (s.bit_cnt == 3'h0);
    assign idle      = (s.phase == flash_erase_pkg::PH_IDLE);

    // Opcode classes
    // The opcode byte stands from its last bit until the next frame's first byte
    assign is_block = (s.opcode == flash_erase_pkg::OP_ERASE_4K)
                    | (s.opcode == flash_erase_pkg::OP_ERASE_32K)
                    | (s.opcode == flash_erase_pkg::OP_ERASE_64K);        // see [RULE_01]
    assign is_chip  = (s.opcode == flash_erase_pkg::OP_CHIP_ERASE_A)
                    | (s.opcode == flash_erase_pkg::OP_CHIP_ERASE_B);     // see [RULE_14]

    // Block size picks which low address bits are dropped
    // 4K is the default, so an opcode of no block erase never widens a region
    always_comb
    begin
        case (s.opcode)
            flash_erase_pkg::OP_ERASE_32K: low_mask = flash_erase_pkg::MASK_32K;
            flash_erase_pkg::OP_ERASE_64K: low_mask = flash_erase_pkg::MASK_64K;
            default:                       low_mask = flash_erase_pkg::MASK_4K;
        endcase
    end

    // Region asked of the protection map
    // Both bounds stand from the last address byte until the next frame
    assign region_base_o = s.addr & ~low_mask;                            // see [RULE_06]
    assign region_last_o = s.addr | low_mask;

    // Next-state logic
    // Defaults hold every field; the start pulse drops after one cycle
    always_comb
    begin
        next_s          = s;
        next_s.start    = 1'b0;
        // Pins pass two flops before anything reads them
        next_s.cs_sync  = {s.cs_sync[0], spi_cs_n_i};
        next_s.sck_sync = {s.sck_sync[0], spi_sck_i};
        next_s.si_sync  = {s.si_sync[0], spi_si_i};
        next_s.sck_prev = s.sck_sync[1];
        next_s.cs_prev  = s.cs_sync[1];

        // New frame clears the byte counters
        // A partial byte left from the last frame is dropped here
        if (cs_fall)
        begin
            next_s.bit_cnt  = 3'h0;
            next_s.byte_cnt = 3'h0;
        end
        // Shift one bit per serial clock while selected
        // Data is taken on the same synchronised edge as the clock
        else if (sck_rise && !s.cs_sync[1])
        begin
            next_s.shift   = full_byte;                                   // see [RULE_22]
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            // A whole byte has arrived
            if (s.bit_cnt == 3'h7)
            begin
                if (s.byte_cnt == 3'h0)
                begin
                    next_s.opcode = full_byte;
                end
                else if (s.byte_cnt <= flash_erase_pkg::ADDR_BYTES)
                begin
                    // Address fills from the top byte, A23 to A16 first
                    next_s.addr = {s.addr[15:0], full_byte};              // see [RULE_03]
                end
                // Later bytes are counted no further and dropped
                if (s.byte_cnt <= flash_erase_pkg::ADDR_BYTES)
                begin
                    // Stops at four: the opcode and three address bytes
                    next_s.byte_cnt = s.byte_cnt + 3'h1;                  // see [RULE_04]
                end
            end
        end

        // Commands act only at frame end and only between erases
        // Frames that end while busy are dropped, write enable included,
        // and a frame with no whole byte leaves everything as it was
        if (cs_rise && idle && s.byte_cnt != 3'h0)
        begin
            // Write enable: whole opcode and clean boundary, else no change
            if (s.opcode == flash_erase_pkg::OP_WRITE_ENABLE)
            begin
                // Only a clean byte boundary sets it; otherwise unchanged
                if (aligned)
                begin
                    next_s.latch = 1'b1;                                  // see [RULE_19], [RULE_21]
                end
            end
            // Block erase: latch gate first, then completeness, then protection
            else if (is_block && s.latch)                                 // see [RULE_02], [RULE_20]
            begin
                // Short address or ragged last byte: abort, drop the latch
                if (!aligned || s.byte_cnt <= flash_erase_pkg::ADDR_BYTES)
                begin
                    next_s.latch = 1'b0;                                  // see [RULE_07], [RULE_09]
                end
                // Region holds a protected sector: refuse, drop the latch
                else if (region_protected_i)
                begin
                    next_s.latch = 1'b0;                                  // see [RULE_08], [RULE_09]
                end
                else
                begin
                    // Start the timed block erase
                    next_s.phase  = flash_erase_pkg::PH_ERASE;            // see [RULE_04]
                    next_s.timer  = 32'(BLOCK_CYCLES);                    // see [RULE_05]
                    next_s.cursor = region_base_o;                        // see [RULE_06]
                    next_s.last   = region_last_o;
                    next_s.start  = 1'b1;
                    // Error flag starts clean with every cycle
                    next_s.err    = 1'b0;
                end
            end
            // Chip erase: needs only the opcode
            else if (is_chip && s.latch)                                  // see [RULE_15], [RULE_20]
            begin
                // Ragged frame: nothing happens and the latch is kept
                if (!aligned)
                begin
                    next_s.latch = s.latch;                               // see [RULE_17]
                end
                // Any protected sector refuses the whole array
                else if (any_protected_i)
                begin
                    next_s.latch = 1'b0;                                  // see [RULE_18]
                end
                else
                begin
                    // Start the timed whole-array erase
                    next_s.phase  = flash_erase_pkg::PH_ERASE;            // see [RULE_16]
                    next_s.timer  = 32'(CHIP_CYCLES);
                    next_s.cursor = '0;
                    next_s.last   = flash_erase_pkg::ARRAY_LAST;
                    next_s.start  = 1'b1;
                    // Same clean error flag as a block erase
                    next_s.err    = 1'b0;
                end
            end
        end

        // Self-timed cycle, runs with no serial clock
        // Erase phase counts the timer down, verify phase walks the region
        case (s.phase)
            flash_erase_pkg::PH_IDLE:
            begin
                // Nothing runs; a start taken above has loaded the timer
                // and this branch must leave that value alone
            end
            flash_erase_pkg::PH_ERASE:
            begin
                // Latch drops once the erase is under way
                next_s.latch = 1'b0;                                      // see [RULE_11]
                // The last count moves on to verify
                if (s.timer <= 32'h1)
                begin
                    next_s.phase = flash_erase_pkg::PH_VERIFY;            // see [RULE_05]
                    next_s.timer = '0;
                end
                else
                begin
                    next_s.timer = s.timer - 32'h1;
                end
            end
            flash_erase_pkg::PH_VERIFY:
            begin
                // Each byte must read back erased
                if (verify_data_i != flash_erase_pkg::ERASED_BYTE)
                begin
                    // A miss stays set until the next start
                    next_s.err = 1'b1;                                    // see [RULE_13]
                end
                if (s.cursor == s.last)
                begin
                    next_s.phase = flash_erase_pkg::PH_IDLE;
                end
                else
                begin
                    next_s.cursor = s.cursor + 24'h1;
                end
            end
            default:
            begin
                next_s.phase = flash_erase_pkg::PH_IDLE;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            // Only constants load here
            s          <= '0;
            // Deselected start, so no false frame follows reset
            s.cs_sync  <= 2'h3;
            s.cs_prev  <= 1'b1;
            s.phase    <= flash_erase_pkg::PH_IDLE;
            s.latch    <= flash_erase_pkg::LATCH_RST;
            s.err      <= flash_erase_pkg::ERR_RST;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    // Busy covers both the erase and the verify phase
    assign busy_o                     = ~idle;                            // see [RULE_10]
    assign write_enable_latch_o       = s.latch;                          // see [RULE_20]
    assign erase_program_error_flag_o = s.err;
    assign erase_start_o              = s.start;
    assign erase_base_o               = s.cursor;
    assign erase_last_o               = s.last;
    // Verify reads walk the region one byte per cycle
    assign verify_rd_o                = (s.phase == flash_erase_pkg::PH_VERIFY);
    assign verify_addr_o              = s.cursor;

endmodule : flash_erase_ctrl

`default_nettype wire

// [hw/flash_erase_pkg.sv]
// Shared constants, types and the state record of the erase and write-enable block.
// Assumes a 100 MHz core clock and a mode 0 serial link, most significant bit first.
package flash_erase_pkg;

    // Command opcodes
    localparam logic [7:0] OP_ERASE_4K     = 8'h20;
    localparam logic [7:0] OP_ERASE_32K    = 8'h52;
    localparam logic [7:0] OP_ERASE_64K    = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;

    // Address layout and region sizes
    localparam int          ADDR_W        = 24;
    localparam logic [2:0]  ADDR_BYTES    = 3'h3;
    localparam logic [23:0] MASK_4K       = 24'h000fff;
    localparam logic [23:0] MASK_32K      = 24'h007fff;
    localparam logic [23:0] MASK_64K      = 24'h00ffff;
    localparam logic [23:0] ARRAY_LAST    = 24'h0fffff;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;

    // Reset values of the status bits
    localparam logic        LATCH_RST     = 1'b0;
    localparam logic        ERR_RST       = 1'b0;

    // Self-timed erase figures, microseconds; cycle counts round down
    localparam int CLK_PERIOD_NS          = 10;
    localparam int BLOCK_ERASE_TIME_US    = 50000;
    localparam int CHIP_ERASE_TIME_US     = 4000000;
    localparam int BLOCK_ERASE_CYCLES     = BLOCK_ERASE_TIME_US * (1000 / CLK_PERIOD_NS);
    localparam int CHIP_ERASE_CYCLES      = CHIP_ERASE_TIME_US * (1000 / CLK_PERIOD_NS);

    // Phases of the self-timed cycle
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ERASE,
        PH_VERIFY
    } phase_t;

    // Whole state of the block
    typedef struct packed {
        logic [1:0]  cs_sync;   // Chip select synchroniser, [1] is safe
        logic [1:0]  sck_sync;  // Serial clock synchroniser
        logic [1:0]  si_sync;   // Serial data synchroniser
        logic        sck_prev;  // Last safe serial clock level
        logic        cs_prev;   // Last safe chip select level
        logic [2:0]  bit_cnt;   // Bits of the current byte
        logic [2:0]  byte_cnt;  // Whole bytes of the frame, saturating
        logic [7:0]  shift;     // Byte being assembled
        logic [7:0]  opcode;    // First byte of the frame
        logic [23:0] addr;      // Address bytes
        phase_t      phase;     // Self-timed phase
        logic [31:0] timer;     // Erase time left
        logic [23:0] cursor;    // Region start, then verify pointer
        logic [23:0] last;      // Last byte of the region
        logic        latch;     // Write enable latch
        logic        err;       // Erase error flag
        logic        start;     // One-cycle erase start pulse
    } state_t;

endpackage : flash_erase_pkg

// [verification/flash_erase_ctrl_asserts.sv]
// Checker for the erase controller outputs.
// Bound to every flash_erase_ctrl instance; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module flash_erase_ctrl_asserts #(
    parameter int BLOCK_CYCLES = 10 // Shortest erase phase
) (
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        busy_o,
    input wire logic        write_enable_latch_o,
    input wire logic        erase_program_error_flag_o,
    input wire logic        erase_start_o,
    input wire logic [23:0] erase_base_o,
    input wire logic [23:0] erase_last_o,
    input wire logic        verify_rd_o,
    input wire logic [23:0] verify_addr_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    logic [31:0] run_cnt; // Busy cycles since the last start
    // Counts the length of each erase cycle
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i || erase_start_o)
            run_cnt <= '0;
        else if (busy_o)
            run_cnt <= run_cnt + 32'h1;
    end
    // Start is a lone pulse, then busy stands
    sequence s_pulse; erase_start_o ##1 !erase_start_o; endsequence
    sequence s_hold; busy_o [*8]; endsequence
    property p_pulse; erase_start_o |-> s_pulse; endproperty
    property p_busy; erase_start_o |-> s_hold; endproperty
    property p_rose; $rose(busy_o) |-> erase_start_o; endproperty
    property p_latch; erase_start_o |-> ##[1:2] !write_enable_latch_o; endproperty
    property p_err; erase_start_o |=> !erase_program_error_flag_o; endproperty
    property p_span;
        erase_start_o |-> ((erase_last_o - erase_base_o) inside
            {24'h000fff, 24'h007fff, 24'h00ffff, 24'h0fffff})
            && ((erase_base_o & (erase_last_o - erase_base_o)) == 24'h0);
    endproperty
    property p_step;
        verify_rd_o && $past(verify_rd_o) |-> verify_addr_o == $past(verify_addr_o) + 24'h1;
    endproperty
    property p_vbusy;
        $fell(busy_o) |-> $past(verify_rd_o) && ($past(verify_addr_o) == erase_last_o);
    endproperty
    property p_len; $fell(busy_o) |-> run_cnt >= BLOCK_CYCLES; endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    a_busy: assert property (p_busy) else $error("busy dropped early");
    a_rose: assert property (p_rose) else $error("busy without start");
    a_latch: assert property (p_latch) else $error("latch kept in erase");
    a_err: assert property (p_err) else $error("error flag kept");
    a_span: assert property (p_span) else $error("bad erase region");
    a_step: assert property (p_step) else $error("verify skipped byte");
    a_vbusy: assert property (p_vbusy) else $error("busy ended before last byte");
    a_len: assert property (p_len) else $error("erase too short");
endmodule : flash_erase_ctrl_asserts
bind flash_erase_ctrl flash_erase_ctrl_asserts #(.BLOCK_CYCLES(BLOCK_CYCLES)) u_chk (
    .core_clk_i, .nrst_i, .busy_o, .write_enable_latch_o, .erase_program_error_flag_o,
    .erase_start_o, .erase_base_o, .erase_last_o, .verify_rd_o, .verify_addr_o);
`default_nettype wire

// [verification/flash_host_model.sv]
// Host serial controller: mode 0 frames, clock idle low.
// Assumes a 100 MHz core clock; calls come from the bench.
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
    input  wire logic clk_i,  // Core clock
    output logic      cs_n_o, // Chip select, active low
    output logic      sck_o,  // Serial clock
    output logic      si_o    // Serial data
);
    localparam int HALF = 5; // Core cycles per clock half
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // Waits n edges, then steps off the edge
    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : hold
    // Sends n bits of d from the top, opcode first
    task automatic frame(input logic [47:0] d, input int n);
        int i;
        hold(1);
        cs_n_o = 1'b0;
        hold(4);
        for (i = 0; i < n; i++)
        begin
            si_o = d[47-i];
            hold(HALF);
            sck_o = 1'b1;
            hold(HALF);
            sck_o = 1'b0;
        end
        hold(HALF);
        cs_n_o = 1'b1;
        si_o = ~si_o; // Released line shows no stale bit
        hold(8);
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

// [verification/test_serial_flash_erase_and_write_enable.sv]
// Self-checking bench for the erase and write-enable controller.
// Assumes the host model and the bound checker; erase times shortened.
`timescale 1ns/1ns
`default_nettype none
module test_serial_flash_erase_and_write_enable;
    typedef struct packed { logic [23:0] base; logic [23:0] last; } region_t;
    logic        core_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        prot = 1'b0;  // Region protection answer
    logic        anyp = 1'b0;  // Some sector protected
    logic [23:0] bad = 24'h0;  // Byte that fails to erase
    logic [7:0]  chip_op [2] = '{8'h60, 8'hc7};
    wire logic   cs_n, sck, si, busy, latch, err, start;
    wire logic [23:0] base, last, vaddr, rbase, rlast;
    wire logic [7:0]  vdata;
    region_t     notes[$];     // Expected erase regions
    int          seed = 90;
    int          miscompares = 0;
    int          check_count = 0;
    int          k;
    always #5 core_clk_i = ~core_clk_i;
    // Array reads erased except one chosen byte
    assign vdata = (vaddr == bad) ? 8'h00 : 8'hff;
    flash_erase_ctrl #(.BLOCK_CYCLES(10), .CHIP_CYCLES(20)) u_flash_erase_ctrl (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .spi_cs_n_i(cs_n), .spi_sck_i(sck),
        .spi_si_i(si), .region_protected_i(prot), .any_protected_i(anyp),
        .verify_data_i(vdata), .busy_o(busy), .write_enable_latch_o(latch),
        .erase_program_error_flag_o(err), .erase_start_o(start), .erase_base_o(base),
        .erase_last_o(last), .region_base_o(rbase), .region_last_o(rlast), .verify_rd_o(),
        .verify_addr_o(vaddr));
    flash_host_model u_flash_host_model (.clk_i(core_clk_i), .cs_n_o(cs_n), .sck_o(sck),
        .si_o(si));
    task automatic chk_flag(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag
    task automatic chk_region(input region_t exp, input region_t got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error erase_region expected %h seen %h", exp, got);
        end
    endtask : chk_region
    task automatic print_verdict();
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // Each start takes the oldest expected region, read mid-cycle while it stands
    always @(negedge core_clk_i)
    begin
        if (start === 1'b1 && notes.size() == 0)
            chk_flag("erase_start", 1'b0, 1'b1);
        else if (start === 1'b1)
            chk_region(notes.pop_front(), {base, last});
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic send(input logic [47:0] d, input int n);
        u_flash_host_model.frame(d, n);
        tick(4);
    endtask : send
    task automatic wren();
        send({8'h06, 8'ha5, 32'h0}, 16);
        chk_flag("latch", 1'b1, latch);
    endtask : wren
    task automatic restart();
        nrst_i = 1'b0;
        tick(3);
        nrst_i = 1'b1;
        tick(3);
    endtask : restart
    // Mode 0 runs clean, 1 hits a bad byte, 2 is cut by reset
    task automatic block(input logic [7:0] op, input logic [23:0] msk, input int mode);
        logic [23:0] a;
        int i;
        a = 24'($random(seed)) & flash_erase_pkg::ARRAY_LAST;
        bad = (mode == 1) ? a : (a ^ 24'h080000);
        wren();
        notes.push_back({a & ~msk, a | msk});
        send({op, a, 16'h5aa5}, 48);
        if (mode == 2)
            restart();
        else
        begin
            for (i = 0; i < 40000 && busy !== 1'b0; i++)
                tick(1);
            chk_flag("busy", 1'b0, busy);
            chk_flag("latch", 1'b0, latch);
            chk_flag("err_flag", mode == 1, err);
        end
    endtask : block
    initial
    begin
        #1000000;
        miscompares++;
        print_verdict();
    end
    initial
    begin
        tick(3);
        nrst_i = 1'b1;
        tick(3);
        chk_flag("latch", flash_erase_pkg::LATCH_RST, latch);
        chk_flag("err_flag", flash_erase_pkg::ERR_RST, err);
        send({8'h20, 24'h001000, 16'h0}, 32);
        chk_flag("busy", 1'b0, busy);
        send({8'h06, 40'h0}, 7);
        chk_flag("latch", 1'b0, latch);
        wren();
        send({8'h20, 16'h0010, 24'h0}, 24);
        chk_flag("latch", 1'b0, latch);
        wren();
        send({8'h52, 24'h002000, 16'h0}, 35);
        chk_flag("latch", 1'b0, latch);
        wren();
        prot = 1'b1;
        send({8'hd8, 24'h030000, 16'h0}, 32);
        chk_flag("latch", 1'b0, latch);
        chk_region({24'h030000, 24'h03ffff}, {rbase, rlast});
        prot = 1'b0;
        anyp = 1'b1;
        for (k = 0; k < 2; k++)
        begin
            wren();
            send({chip_op[k], 40'h0}, 8);
            chk_flag("latch", 1'b0, latch);
        end
        anyp = 1'b0;
        wren();
        send({8'hc7, 40'h0}, 13);
        chk_flag("latch", 1'b1, latch);
        for (k = 0; k < 2; k++)
        begin
            wren();
            notes.push_back({24'h0, flash_erase_pkg::ARRAY_LAST});
            send({chip_op[k], 8'h33, 32'h0}, 16);
            restart();
        end
        send({8'h60, 40'h0}, 8);
        chk_flag("busy", 1'b0, busy);
        block(8'h20, flash_erase_pkg::MASK_4K, 1);
        block(8'h52, flash_erase_pkg::MASK_32K, 0);
        block(8'hd8, flash_erase_pkg::MASK_64K, 2);
        chk_flag("notes_left", 1'b1, notes.size() == 0);
        print_verdict();
    end
endmodule : test_serial_flash_erase_and_write_enable
`default_nettype wire
